// ===== logic/uaw_pkg.sv
// Purpose: Shared constants and carrier types for the serial auto-wake-up block
// Assumes: Single 40 MHz system clock, synchronous active-high reset
// Notes: No register bus; control and status bits are plain ports
package uaw_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ = 40000000;  // System clock rate
  localparam int unsigned SYNC_STAGES = 3;    // Pin synchroniser depth

  // ==========================================================================
  // Baud control register layout
  // ==========================================================================
  localparam int unsigned BAUDCTL_W = 8;      // Width of baud control register
  localparam int unsigned WAKE_EN_BIT = 1;    // Wake-on-edge enable position
  localparam logic [7:0] BAUDCTL_RST = 8'h00; // Reset value
  localparam logic [7:0] RXDATA_RST = 8'h00;  // Receive data reset value

  // ==========================================================================
  // Receiver state machine
  // ==========================================================================
  typedef enum logic [1:0] {
    UAW_RX_IDLE = 2'b00,  // Waiting for a start bit
    UAW_RX_BUSY = 2'b01,  // Character in progress
    UAW_WAKE_ARM = 2'b10, // Armed, watching for falling edge
    UAW_WAKE_LOW = 2'b11  // Wake event seen, waiting for rising edge
  } uaw_state_t;

  // Software control carrier
  typedef struct packed {
    logic async_mode;   // Port is in asynchronous mode
    logic sleep;        // Device in sleep: serial clocks stopped
    logic wake_set;     // Pulse: software sets the wake enable bit
    logic rxdata_read;  // Pulse: software reads the receive data register
  } uaw_ctrl_t;

  // Status carrier
  typedef struct packed {
    logic wake_on_edge_enable;     // Enable bit as stored
    logic receive_interrupt_flag;  // Receive interrupt request
    logic receive_idle_status;     // One when no reception in progress
    logic wake_flag;               // Flag raised by a wake event
  } uaw_stat_t;

endpackage : uaw_pkg

// ===== logic/uaw_sync.sv
// Purpose: Multi-stage synchroniser with agreement-based change detection
// Assumes: Input is asynchronous to clk
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module uaw_sync #(
  parameter int unsigned STAGES = 3,
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Asynchronous input
  input wire logic d_async,
  // Filtered level
  output logic q
);

  // ==========================================================================
  // Stage chain
  // ==========================================================================
  logic [STAGES-1:0] chain_q; // Synchroniser flops

  // Shift the pin through the chain
  always_ff @(posedge clk) begin
    if (srst) begin
      chain_q <= {STAGES{RST_VAL}};
    end else begin
      chain_q <= {chain_q[STAGES-2:0], d_async};
    end
  end

  // Output changes only when the two last stages agree
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= RST_VAL;
    end else if (chain_q[STAGES-1] == chain_q[STAGES-2]) begin
      q <= chain_q[STAGES-1];
    end
  end

endmodule : uaw_sync

// ===== logic/uaw_wake.sv
// Purpose: Auto-wake-up on break for an asynchronous serial receiver
// Assumes: Normal receive sequence runs elsewhere and reports done; busy is tracked here from the falling edge
// Notes: Sleep edge latch is modelled with the system clock kept alive
//
// Contract
// (R1) Setting wake enable bit arms wake-up
// (R2) Armed: suppress reception, hold receiver idle
// (R3) Falling receive edge is the wake event
// (R4) Wake event sets receive interrupt flag
// (R5) Flag set synchronously awake, latched in sleep
// (R6) Reading receive data clears wake interrupt
// (R7) Rising edge after wake clears enable, idles
// (R8) Sleep stops serial clocks, no reception
// (R9) Wake detection only in asynchronous mode
// (R10) Any rising edge after wake ends state
// (R11) Remote sends all-zero first character
// (R12) Remote break long enough for oscillator start
// (R13) Software discards data read after wake
// (R14) Software checks data integrity separately
// (R15) Idle status reported; arm only when idle
// (R16) Idle status one idle, zero receiving
// (R17) Falling edge latched without needing clock
`timescale 1ns/1ps
module uaw_wake (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Serial line
  input wire logic serial_receive_line,
  // Software control
  input wire uaw_pkg::uaw_ctrl_t ctrl,
  // Normal receiver handshake
  input wire logic rx_char_done,
  input wire logic [7:0] rx_char_data,
  // Status and receive data
  output uaw_pkg::uaw_stat_t stat,
  output logic [7:0] receive_data_register,
  output logic serial_clk_en,
  output logic rx_run_en
);

  // ==========================================================================
  // Input synchroniser
  // ==========================================================================
  logic rx_s;      // Filtered receive level
  logic rx_prev_q; // Previous filtered level

  uaw_sync #(.STAGES(uaw_pkg::SYNC_STAGES), .RST_VAL(1'b1)) u_sync (
    .clk(clk),
    .srst(srst),
    .d_async(serial_receive_line),
    .q(rx_s)
  );

  // Remember last level for edge detection
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_s;
    end
  end

  logic fall; // Falling edge on receive line
  logic rise; // Rising edge on receive line
  assign fall = rx_prev_q & ~rx_s; // R3
  assign rise = ~rx_prev_q & rx_s;

  // ==========================================================================
  // State machine
  // ==========================================================================
  uaw_pkg::uaw_state_t state_q; // Current state
  uaw_pkg::uaw_state_t state_d; // Next state
  logic armable;                // Wake allowed now
  assign armable = ctrl.async_mode; // R9

  // Next-state decision
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      uaw_pkg::UAW_RX_IDLE: begin
        if (ctrl.wake_set && armable) begin
          state_d = uaw_pkg::UAW_WAKE_ARM; // R1
        end else if (fall && !ctrl.sleep) begin
          state_d = uaw_pkg::UAW_RX_BUSY;
        end
      end
      uaw_pkg::UAW_RX_BUSY: begin
        // Reception ends on done; sleep aborts it
        if (rx_char_done || ctrl.sleep) begin
          state_d = uaw_pkg::UAW_RX_IDLE; // R8
        end
      end
      uaw_pkg::UAW_WAKE_ARM: begin
        if (!armable) begin
          state_d = uaw_pkg::UAW_RX_IDLE; // R9
        end else if (fall) begin
          state_d = uaw_pkg::UAW_WAKE_LOW; // R2 R3
        end
      end
      uaw_pkg::UAW_WAKE_LOW: begin
        if (rise || !armable) begin
          state_d = uaw_pkg::UAW_RX_IDLE; // R7 R10
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= uaw_pkg::UAW_RX_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  logic armed_d; // Enable bit next value
  assign armed_d = (state_d == uaw_pkg::UAW_WAKE_ARM) || (state_d == uaw_pkg::UAW_WAKE_LOW);
  logic wake_evt; // Wake event this cycle
  assign wake_evt = (state_q == uaw_pkg::UAW_WAKE_ARM) && armable && fall;

  // ==========================================================================
  // Status flags
  // ==========================================================================
  // Wake flag: latched event, set wins over read clear; holds through sleep
  always_ff @(posedge clk) begin
    if (srst) begin
      stat.wake_flag <= 1'b0;
    end else if (wake_evt) begin
      stat.wake_flag <= 1'b1; // R4 R5 R17
    end else if (ctrl.rxdata_read) begin
      stat.wake_flag <= 1'b0; // R6
    end
  end

  // Receive interrupt flag: wake event or completed character
  always_ff @(posedge clk) begin
    if (srst) begin
      stat.receive_interrupt_flag <= 1'b0;
    end else if (wake_evt || (rx_char_done && state_q == uaw_pkg::UAW_RX_BUSY)) begin
      stat.receive_interrupt_flag <= 1'b1; // R4
    end else if (ctrl.rxdata_read) begin
      stat.receive_interrupt_flag <= 1'b0; // R6
    end
  end

  // Enable bit mirror
  always_ff @(posedge clk) begin
    if (srst) begin
      stat.wake_on_edge_enable <= uaw_pkg::BAUDCTL_RST[uaw_pkg::WAKE_EN_BIT];
    end else begin
      stat.wake_on_edge_enable <= armed_d; // R1 R7
    end
  end

  // Idle status: low only while a character is received
  always_ff @(posedge clk) begin
    if (srst) begin
      stat.receive_idle_status <= 1'b1;
    end else begin
      stat.receive_idle_status <= (state_d != uaw_pkg::UAW_RX_BUSY); // R15 R16
    end
  end

  // ==========================================================================
  // Receive data and clock gating
  // ==========================================================================
  // Capture characters only from normal reception
  always_ff @(posedge clk) begin
    if (srst) begin
      receive_data_register <= uaw_pkg::RXDATA_RST;
    end else if (rx_char_done && state_q == uaw_pkg::UAW_RX_BUSY) begin
      receive_data_register <= rx_char_data; // R2
    end
  end

  // Serial clocks stop in sleep
  always_ff @(posedge clk) begin
    if (srst) begin
      serial_clk_en <= 1'b0;
    end else begin
      serial_clk_en <= ~ctrl.sleep; // R8
    end
  end

  // Receiver sequencer runs only when not armed and not asleep
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_run_en <= 1'b0;
    end else begin
      rx_run_en <= ~armed_d & ~ctrl.sleep; // R2 R8
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_wake_sets_flag;
    @(posedge clk) disable iff (srst)
    wake_evt |=> stat.receive_interrupt_flag && stat.wake_flag;
  endproperty
  a_wake_sets_flag: assert property (p_wake_sets_flag) else $error("wake flag not set"); // R4

  property p_read_clears;
    @(posedge clk) disable iff (srst)
    ctrl.rxdata_read && !wake_evt && !rx_char_done |=> !stat.wake_flag;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear"); // R6

  property p_rise_disarms;
    @(posedge clk) disable iff (srst)
    state_q == uaw_pkg::UAW_WAKE_LOW && rise |=> !stat.wake_on_edge_enable;
  endproperty
  a_rise_disarms: assert property (p_rise_disarms) else $error("enable not cleared"); // R7

  property p_arm;
    @(posedge clk) disable iff (srst)
    state_q == uaw_pkg::UAW_RX_IDLE && ctrl.wake_set && ctrl.async_mode
      |=> stat.wake_on_edge_enable;
  endproperty
  a_arm: assert property (p_arm) else $error("enable not armed"); // R1

  property p_armed_no_run;
    @(posedge clk) disable iff (srst)
    stat.wake_on_edge_enable |-> !rx_run_en;
  endproperty
  a_armed_no_run: assert property (p_armed_no_run) else $error("receiver ran while armed"); // R2

  property p_fall_wakes;
    @(posedge clk) disable iff (srst)
    state_q == uaw_pkg::UAW_WAKE_ARM && ctrl.async_mode && fall
      |=> state_q == uaw_pkg::UAW_WAKE_LOW;
  endproperty
  a_fall_wakes: assert property (p_fall_wakes) else $error("edge missed"); // R3

  property p_sleep_clk;
    @(posedge clk) disable iff (srst)
    ctrl.sleep |=> !serial_clk_en && !rx_run_en;
  endproperty
  a_sleep_clk: assert property (p_sleep_clk) else $error("clocks run in sleep"); // R8

  property p_sync_only;
    @(posedge clk) disable iff (srst)
    !ctrl.async_mode |=> !stat.wake_on_edge_enable;
  endproperty
  a_sync_only: assert property (p_sync_only) else $error("armed in sync mode"); // R9

  property p_idle_stat;
    @(posedge clk) disable iff (srst)
    state_q == uaw_pkg::UAW_RX_BUSY |-> !stat.receive_idle_status;
  endproperty
  a_idle_stat: assert property (p_idle_stat) else $error("idle wrong"); // R16

  c_wake: cover property (@(posedge clk) disable iff (srst) wake_evt);
  c_disarm: cover property (@(posedge clk) disable iff (srst)
    state_q == uaw_pkg::UAW_WAKE_LOW ##1 state_q == uaw_pkg::UAW_RX_IDLE);
  c_sleep_wake: cover property (@(posedge clk) disable iff (srst) ctrl.sleep && wake_evt);

endmodule : uaw_wake

// ===== testbench/test_uaw_wake.sv
// Purpose: Self-checking bench for the serial auto-wake-up block
// Assumes: Inputs driven at falling edges; normal receiver emulated here
// Notes: Wake event, early end, refusal, sleep and read clear are exercised
`timescale 1ns/1ps
module test_uaw_wake;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk = 1'b0;                  // System clock
  logic srst = 1'b1;                 // Synchronous reset
  uaw_pkg::uaw_ctrl_t ctrl = '0;     // Software controls
  logic rx_char_done = 1'b0;         // Emulated receiver done
  logic [7:0] rx_char_data = 8'h00;  // Emulated receiver data
  logic line;                        // Serial line
  uaw_pkg::uaw_stat_t stat;          // Status bits
  logic [7:0] rdata;                 // Receive data register
  logic clk_en;                      // Serial clock enable
  logic run_en;                      // Normal receiver enable
  int miscompares = 0;               // Mismatch count
  int n_tests = 0;                   // Comparison count
  int cycles = 0;                    // Timeout counter

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Remote transmitter
  uaw_remote_tx #(.BIT_CYC(8)) tx (.clk(clk), .serial_receive_line(line));

  // Device under test
  uaw_wake DUT (.clk(clk), .srst(srst), .serial_receive_line(line), .ctrl(ctrl),
    .rx_char_done(rx_char_done), .rx_char_data(rx_char_data), .stat(stat),
    .receive_data_register(rdata), .serial_clk_en(clk_en), .rx_run_en(run_en));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Compare and report
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Single-bit compare
  task chb(input logic seen, input logic exp);
    chk({7'h00, seen}, {7'h00, exp});
  endtask : chb

  // Wait whole cycles, ending on a falling edge
  task wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cyc

  // Software sets the wake enable bit
  task set_wake;
    @(negedge clk) ctrl.wake_set = 1'b1;
    @(negedge clk) ctrl.wake_set = 1'b0;
  endtask : set_wake

  // Software reads the receive data register
  task read_data;
    @(negedge clk) ctrl.rxdata_read = 1'b1;
    @(negedge clk) ctrl.rxdata_read = 1'b0;
  endtask : read_data

  // Emulated receiver finishes a character
  task char_done(input logic [7:0] d);
    @(negedge clk) begin
      rx_char_done = 1'b1;
      rx_char_data = d;
    end
    @(negedge clk) rx_char_done = 1'b0;
  endtask : char_done

  // Closing report
  task end_sim;
    $display("checks=%0d mismatches=%0d", n_tests, miscompares);
    // Verdict: a clean run needs at least one comparison
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_sim;
    end
  end

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    wait_cyc(4);
    srst = 1'b0;
    chb(stat.wake_on_edge_enable, 1'b0);
    chb(stat.receive_idle_status, 1'b1);
    chk(rdata, 8'h00);
    ctrl.async_mode = 1'b1;
    wait_cyc(6);
    chb(clk_en, 1'b1);
    chb(run_en, 1'b1);
    // Normal character; arming refused while it runs
    fork tx.send_char(8'h5a); join_none
    wait_cyc(10);
    chb(stat.receive_idle_status, 1'b0);
    set_wake;
    chb(stat.wake_on_edge_enable, 1'b0);
    wait fork;
    char_done(8'h5a);
    wait_cyc(2);
    chk(rdata, 8'h5a);
    chb(stat.receive_idle_status, 1'b1);
    // Clear the flag left by the normal character so the wake check means something
    read_data;
    chb(stat.receive_interrupt_flag, 1'b0);
    // Arming refused outside asynchronous mode
    ctrl.async_mode = 1'b0;
    wait_cyc(2);
    set_wake;
    chb(stat.wake_on_edge_enable, 1'b0);
    ctrl.async_mode = 1'b1;
    wait_cyc(2);
    // Wake on zero character while awake
    set_wake;
    chb(stat.wake_on_edge_enable, 1'b1);
    wait_cyc(1);
    chb(run_en, 1'b0);
    fork tx.send_char(8'h00); join_none
    wait_cyc(20);
    chb(stat.wake_flag, 1'b1);
    chb(stat.receive_interrupt_flag, 1'b1);
    chb(stat.wake_on_edge_enable, 1'b1);
    chb(stat.receive_idle_status, 1'b1);
    char_done(8'h33);
    wait_cyc(2);
    chk(rdata, 8'h5a);
    wait fork;
    chb(stat.wake_on_edge_enable, 1'b0);
    chb(run_en, 1'b1);
    read_data;
    chb(stat.receive_interrupt_flag, 1'b0);
    chb(stat.wake_flag, 1'b0);
    // Non-zero first character ends the wake state early
    set_wake;
    fork tx.send_char(8'h01); join_none
    wait_cyc(30);
    chb(stat.wake_on_edge_enable, 1'b0);
    chb(stat.wake_flag, 1'b1);
    wait fork;
    char_done(8'h01);
    read_data;
    chk(rdata, 8'h01);
    // Leaving asynchronous mode disarms
    set_wake;
    chb(stat.wake_on_edge_enable, 1'b1);
    ctrl.async_mode = 1'b0;
    wait_cyc(2);
    chb(stat.wake_on_edge_enable, 1'b0);
    ctrl.async_mode = 1'b1;
    wait_cyc(2);
    // Wake from sleep
    set_wake;
    ctrl.sleep = 1'b1;
    wait_cyc(3);
    chb(clk_en, 1'b0);
    fork tx.send_char(8'h00); join_none
    wait_cyc(20);
    chb(stat.receive_interrupt_flag, 1'b1);
    wait fork;
    chb(stat.wake_on_edge_enable, 1'b0);
    ctrl.sleep = 1'b0;
    read_data;
    chb(stat.receive_interrupt_flag, 1'b0);
    end_sim;
  end
endmodule : test_uaw_wake

// ===== testbench/uaw_remote_tx.sv
// Purpose: Remote serial transmitter model for the wake-up bench
// Assumes: Line idles high; bits change at falling clock edges
// Notes: Bit time shortened to a few system clocks
`timescale 1ns/1ps
module uaw_remote_tx #(
  parameter int BIT_CYC = 8  // System clocks per bit
) (
  // Clock
  input wire logic clk,
  // Serial line towards the device
  output logic serial_receive_line
);
  // ==========================================================================
  // Character sender
  // ==========================================================================
  // Line idles high between characters
  initial begin
    serial_receive_line = 1'b1;
  end

  // Start bit, eight data bits LSB first, stop bit, then idle gap
  task automatic send_char(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      serial_receive_line = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (BIT_CYC - 1) @(negedge clk);
    end
    // Idle time so the receiver recovers before the next character
    repeat (2 * BIT_CYC) @(negedge clk);
  endtask : send_char
endmodule : uaw_remote_tx
